// *** bench/adc_clock_out_and_gpio_bench.sv ***
/*
 * Self-checking bench of the clock output and general-purpose pins.
 * Assumes the design and pin_partner are compiled before this file.
 */
`timescale 1ns/1ps
module adc_clock_out_and_gpio_bench;
    // ************************************************
    // Stimulus and observed signals
    // ************************************************
    logic       ref_clk, rstn, soft_reset, standby, power_down;
    logic       clk_sel_wr, dir_wr, value_wr;
    logic [1:0] clk_sel_wdata, dir_wdata, value_wdata, ext_lvl, pad;
    logic [1:0] clk_sel, pin_dir, pin_value_bits;
    logic       mod_rate_tick, filter_rate_tick;
    logic       pin_zero_out, pin_zero_oe, pin_one_out, pin_one_oe;
    int         edges, n0, n_fail, comparisons;

    adc_clock_out_and_gpio u_adc_clock_out_and_gpio (
        .ref_clk(ref_clk), .rstn(rstn), .soft_reset(soft_reset),
        .standby(standby), .power_down(power_down),
        .clk_sel_wr(clk_sel_wr), .clk_sel_wdata(clk_sel_wdata),
        .dir_wr(dir_wr), .dir_wdata(dir_wdata),
        .value_wr(value_wr), .value_wdata(value_wdata),
        .clk_sel(clk_sel), .pin_dir(pin_dir), .pin_value_bits(pin_value_bits),
        .mod_rate_tick(mod_rate_tick), .filter_rate_tick(filter_rate_tick),
        .pin_zero_in(pad[0]), .pin_zero_out(pin_zero_out), .pin_zero_oe(pin_zero_oe),
        .pin_one_in(pad[1]), .pin_one_out(pin_one_out), .pin_one_oe(pin_one_oe));

    pin_partner u_pin_partner (
        .p0_out(pin_zero_out), .p0_oe(pin_zero_oe), .p1_out(pin_one_out),
        .p1_oe(pin_one_oe), .ext_lvl(ext_lvl), .pad(pad), .edges(edges));

    // Master clock supplied from outside, 4 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ************************************************
    // Shared tasks
    // ************************************************
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Settle for n edges, sample after updates land
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // One write strobe: 0 select, 1 direction, 2 value
    task automatic wr(input int k, input logic [1:0] d);
        @(posedge ref_clk);
        clk_sel_wr    <= (k == 0);
        dir_wr        <= (k == 1);
        value_wr      <= (k == 2);
        clk_sel_wdata <= d;
        dir_wdata     <= d;
        value_wdata   <= d;
        @(posedge ref_clk);
        {clk_sel_wr, dir_wr, value_wr} <= 3'h0;
        wait_n(3);
    endtask

    // Select a clock mode and count pin zero edges over 64 cycles
    task automatic rate(input logic [1:0] sel, input int exp);
        wr(0, sel);
        wait_n(8);
        n0 = edges;
        wait_n(64);
        chk(8'(edges - n0), 8'(exp));
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    // Defaults after hard reset
    task automatic t_reset();
        chk(8'(clk_sel), 8'h01);
        chk(8'(pin_dir), 8'h03);
        chk(8'({pin_zero_oe, pin_one_oe}), 8'h02);
    endtask

    // Select codes 1 to 3, internal rate pulses, then code 0
    task automatic t_rates();
        int m, f;
        m = 0;
        f = 0;
        for (int s = 1; s < 4; s++) begin
            rate(2'(s), 64 >> (s - 1));
        end
        repeat (256) begin
            wait_n(1);
            m += int'(mod_rate_tick);
            f += int'(filter_rate_tick);
        end
        chk(8'(m), 8'h40);
        chk(8'(f), 8'h01);
        rate(2'h0, 0);
        chk(8'(pin_zero_oe), 8'h00);
    endtask

    // Independent directions, value drive and readback
    task automatic t_gpio();
        wr(1, 2'h2);
        chk(8'({pin_zero_oe, pin_one_oe}), 8'h02);
        @(posedge ref_clk);
        ext_lvl <= 2'h2;
        wr(2, 2'h1);
        chk(8'(pin_zero_out), 8'h01);
        chk(8'(pin_value_bits), 8'h03);
        @(posedge ref_clk);
        ext_lvl <= 2'h1;
        wr(2, 2'h0);
        chk(8'(pin_value_bits), 8'h00);
        wr(1, 2'h1);
        rate(2'h1, 64);
        chk(8'(pin_zero_oe), 8'h01);
    endtask

    // Power modes leave clock and driven pins alone
    task automatic t_power();
        wr(1, 2'h1);
        wr(2, 2'h2);
        @(posedge ref_clk);
        standby    <= 1'b1;
        power_down <= 1'b1;
        rate(2'h3, 16);
        chk(8'({pin_one_oe, pin_one_out}), 8'h03);
        chk(8'(pin_value_bits[1]), 8'h01);
        @(posedge ref_clk);
        standby    <= 1'b0;
        power_down <= 1'b0;
    endtask

    // Soft reset keeps select, hard reset restores it
    task automatic t_resets();
        wr(0, 2'h2);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        wait_n(2);
        chk(8'(clk_sel), 8'h02);
        chk(8'(pin_dir), 8'h03);
        @(posedge ref_clk);
        rstn <= 1'b0;
        wait_n(2);
        @(posedge ref_clk);
        rstn <= 1'b1;
        wait_n(2);
        chk(8'(clk_sel), 8'h01);
        chk(8'(pin_zero_oe), 8'h01);
    endtask

    // ************************************************
    // Verdict
    // ************************************************
    task automatic tally_and_finish();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the eight hundred or so cycles needed
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        n_fail = 0;
        comparisons = 0;
        rstn = 1'b0;
        {soft_reset, standby, power_down} = 3'h0;
        {clk_sel_wr, dir_wr, value_wr} = 3'h0;
        {clk_sel_wdata, dir_wdata, value_wdata} = 6'h00;
        ext_lvl = 2'h0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        wait_n(2);
        t_reset();
        t_rates();
        t_gpio();
        t_power();
        t_resets();
        tally_and_finish();
    end
endmodule

// *** bench/pin_partner.sv ***
/*
 * Far side of the pins: external circuits and a device clocked from pin zero.
 * Assumes pad level is the design drive when enabled, else the external level.
 */
`timescale 1ns/1ps
module pin_partner (
    // Design drive of both pins
    input  wire logic       p0_out,
    input  wire logic       p0_oe,
    input  wire logic       p1_out,
    input  wire logic       p1_oe,
    // Level the external circuit drives
    input  wire logic [1:0] ext_lvl,
    // Resolved pad levels
    output logic [1:0]      pad,
    // Rising edges seen by the clocked device
    output int              edges
);
    // ************************************************
    // Pad resolution
    // ************************************************
    // Inputs are always driven, never left floating
    assign pad[0] = p0_oe ? p0_out : ext_lvl[0];
    assign pad[1] = p1_oe ? p1_out : ext_lvl[1];

    // Clocked device counts edges of pin zero
    initial edges = 0;
    always @(posedge pad[0]) begin
        edges = edges + 1;
    end
endmodule

// *** design/adc_clock_out_and_gpio.sv ***
/*
 * Clock output and two general-purpose pins of the converter.
 * Pin zero carries the master clock, full or divided, or a general pin; pin one
 * is a general pin. Assumes the pad resolves level from out and oe,
 * and that ref_clk is the master clock supplied from outside.
 */
`timescale 1ns/1ps
`include "adc_pin_consts.svh"
module adc_clock_out_and_gpio (
    // Master clock and hard reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Other reset means, leaves clock select alone
    input  wire logic       soft_reset,
    // Power modes
    input  wire logic       standby,
    input  wire logic       power_down,
    // Clock select field write
    input  wire logic       clk_sel_wr,
    input  wire logic [1:0] clk_sel_wdata,
    // Direction bits write, 1 = input
    input  wire logic       dir_wr,
    input  wire logic [1:0] dir_wdata,
    // Value bits write
    input  wire logic       value_wr,
    input  wire logic [1:0] value_wdata,
    // Readback
    output logic [1:0]      clk_sel,
    output logic [1:0]      pin_dir,
    output logic [1:0]      pin_value_bits,
    // Rate pulses for internal timing
    output logic            mod_rate_tick,
    output logic            filter_rate_tick,
    // Pin zero
    input  wire logic       pin_zero_in,
    output logic            pin_zero_out,
    output logic            pin_zero_oe,
    // Pin one
    input  wire logic       pin_one_in,
    output logic            pin_one_out,
    output logic            pin_one_oe
);

    adc_pin_pkg::pin_state_t st;   // Registered state
    adc_pin_pkg::pin_state_t nxt;  // Next state
    logic half_clk;                // Master clock / 2
    logic quarter_clk;             // Master clock / 4
    logic phase_end;               // Divider at end of quarter period
    logic clk_src;                 // Selected clock level
    logic clk_on;                  // Clock function owns pin zero

    // ****************************************************
    // Divider
    // ****************************************************
    // Runs on the supplied master clock only
    rate_divider u_div (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .half_clk    (half_clk),
        .quarter_clk (quarter_clk),
        .phase_end   (phase_end),
        .mod_tick    (mod_rate_tick),
        .frame_tick  (filter_rate_tick)
    );

    // ****************************************************
    // Next state
    // ****************************************************
    // Standby and power-down are not looked at: pins stay live
    always_comb begin
        nxt = st;
        // Pad sampling through two flops
        nxt.sync1_ff = {pin_one_in, pin_zero_in};
        nxt.sync2_ff = st.sync1_ff;
        // Soft reset restores pins but not clock select
        if (soft_reset) begin
            nxt.dir_ff = `DIR_RST;
            nxt.val_ff = `VAL_RST;
        end else begin
            // Independent direction bits
            if (dir_wr) begin
                nxt.dir_ff = dir_wdata;
            end
            // Written levels
            if (value_wr) begin
                nxt.val_ff = value_wdata;
            end
        end
        // Select field, hard reset only
        if (clk_sel_wr) begin
            nxt.sel_ff = clk_sel_wdata;
        end
        // New mode lands at divider phase end, no runt pulse except when leaving full rate on the ref_clk rising edge
        if (phase_end) begin
            nxt.mode_ff = adc_pin_pkg::sel_to_mode(st.sel_ff);
        end
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st.sel_ff   <= `CKSEL_RST;
            st.mode_ff  <= adc_pin_pkg::CK_FULL;
            st.dir_ff   <= `DIR_RST;
            st.val_ff   <= `VAL_RST;
            st.sync1_ff <= `SYNC_RST;
            st.sync2_ff <= `SYNC_RST;
        end else begin
            st <= nxt;
        end
    end

    // ****************************************************
    // Clock source
    // ****************************************************
    // Full rate passes the master clock itself
    always_comb begin
        case (st.mode_ff)
            adc_pin_pkg::CK_FULL:    clk_src = ref_clk;
            adc_pin_pkg::CK_HALF:    clk_src = half_clk;
            adc_pin_pkg::CK_QUARTER: clk_src = quarter_clk;
            default:                 clk_src = 1'h0;
        endcase
    end

    assign clk_on = (st.mode_ff != adc_pin_pkg::CK_OFF);

    // ****************************************************
    // Pin drive
    // ****************************************************
    // Clock function overrides pin zero settings
    assign pin_zero_out = clk_on ? clk_src : st.val_ff[0];
    assign pin_zero_oe  = clk_on | (st.dir_ff[0] == `DIR_OUTPUT);
    assign pin_one_out  = st.val_ff[1];
    assign pin_one_oe   = (st.dir_ff[1] == `DIR_OUTPUT);

    // Readback
    assign clk_sel        = st.sel_ff;
    assign pin_dir        = st.dir_ff;
    assign pin_value_bits = st.sync2_ff;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_half_toggle;
        (st.mode_ff == adc_pin_pkg::CK_HALF) && ($past(st.mode_ff) == adc_pin_pkg::CK_HALF)
            |-> pin_zero_out != $past(pin_zero_out);
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("half rate clock did not toggle");

    property p_quarter_period;
        (st.mode_ff == adc_pin_pkg::CK_QUARTER) && ($past(st.mode_ff, 2) == adc_pin_pkg::CK_QUARTER)
            |-> pin_zero_out != $past(pin_zero_out, 2);
    endproperty
    a_quarter_period: assert property (p_quarter_period) else $error("quarter rate clock wrong");

    property p_mode_follows;
        clk_sel_wr ##1 !clk_sel_wr [*5] |-> st.mode_ff == adc_pin_pkg::sel_to_mode(st.sel_ff);
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode did not follow select");

    // Quarter rate must keep toggling on the pin while standby is high
    property p_standby_runs;
        standby && (st.mode_ff == adc_pin_pkg::CK_QUARTER) && ($past(st.mode_ff, 2) == adc_pin_pkg::CK_QUARTER)
            |-> pin_zero_oe && pin_zero_out != $past(pin_zero_out, 2);
    endproperty
    a_standby_runs: assert property (p_standby_runs) else $error("clock output stopped in standby");

    property p_off_gpio;
        (st.mode_ff == adc_pin_pkg::CK_OFF) |-> pin_zero_oe == !st.dir_ff[0] && pin_zero_out == st.val_ff[0];
    endproperty
    a_off_gpio: assert property (p_off_gpio) else $error("pin zero not general when clock off");

    property p_dir_one;
        dir_wr && !soft_reset |=> pin_one_oe == !$past(dir_wdata[1]);
    endproperty
    a_dir_one: assert property (p_dir_one) else $error("pin one direction wrong");

    // Full rate pin zero is the master clock itself, captured on its own edge
    property p_readback;
        $past(rstn, 2) |-> pin_value_bits[1] == $past(pin_one_in, 2)
            && ($past(st.mode_ff, 2) == adc_pin_pkg::CK_FULL || pin_value_bits[0] == $past(pin_zero_in, 2));
    endproperty
    a_readback: assert property (p_readback) else $error("value bits not pin level");

    property p_value_write;
        value_wr && !soft_reset |=> pin_one_out == $past(value_wdata[1]);
    endproperty
    a_value_write: assert property (p_value_write) else $error("value write not driven");

    property p_power_hold;
        (standby || power_down) && !value_wr && !dir_wr && !soft_reset
            |=> $stable(pin_one_out) && $stable(pin_one_oe);
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("pin one changed in low power");

    property p_soft_defaults;
        soft_reset |=> pin_dir == `DIR_RST;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset left directions");

    property p_sel_kept;
        soft_reset && !clk_sel_wr |=> $stable(clk_sel);
    endproperty
    a_sel_kept: assert property (p_sel_kept) else $error("soft reset changed clock select");

    property p_mod_tick;
        mod_rate_tick |=> !mod_rate_tick [*3] ##1 mod_rate_tick;
    endproperty
    a_mod_tick: assert property (p_mod_tick) else $error("modulator rate pulse spacing wrong");

    property p_clk_owns;
        clk_on |-> pin_zero_oe && pin_zero_out == clk_src;
    endproperty
    a_clk_owns: assert property (p_clk_owns) else $error("pin zero settings leaked into clock");

    // Main scenarios
    c_half_mode: cover property (st.mode_ff == adc_pin_pkg::CK_HALF);
    c_clock_off: cover property ($past(clk_on) && !clk_on);
    c_pin_one_out: cover property (pin_one_oe && pin_one_out);
    c_standby_clk: cover property (standby && st.mode_ff == adc_pin_pkg::CK_QUARTER);

endmodule

// *** design/adc_pin_consts.svh ***
/*
 * Constants for the clock output and general-purpose pin block:
 * clock select codes, reset values, direction codes and divider counts.
 * Assumes it is included once per file by its bare name.
 */
`ifndef ADC_PIN_CONSTS_SVH
`define ADC_PIN_CONSTS_SVH

// ****************************************************
// Clock select field codes
// ****************************************************
`define CKSEL_OFF     2'h0
`define CKSEL_FULL    2'h1
`define CKSEL_HALF    2'h2
`define CKSEL_QUARTER 2'h3
`define CKSEL_RST     2'h1

// ****************************************************
// Pin direction and value defaults
// ****************************************************
`define DIR_INPUT     1'h1
`define DIR_OUTPUT    1'h0
`define DIR_RST       2'h3
`define VAL_RST       2'h0
`define SYNC_RST      2'h0

// ****************************************************
// Divider counts
// ****************************************************
`define DIV_CNT_RST   8'h00
`define DIV_CNT_STEP  8'h01
`define DIV_PHASE_END 2'h3
`define DIV_FRAME_END 8'hFF

`endif

// *** design/adc_pin_pkg.sv ***
/*
 * Types for the clock output and general-purpose pin block.
 * Assumes adc_pin_consts.svh is on the include path.
 */
`include "adc_pin_consts.svh"
package adc_pin_pkg;

    // Applied clock output mode, one-hot
    typedef enum logic [3:0] {
        CK_OFF     = 4'h1,
        CK_FULL    = 4'h2,
        CK_HALF    = 4'h4,
        CK_QUARTER = 4'h8
    } ck_mode_t;

    // Main block state
    typedef struct packed {
        logic [1:0] sel_ff;      // Clock select field
        ck_mode_t   mode_ff;     // Mode applied on the pin
        logic [1:0] dir_ff;      // Direction bits, 1 = input
        logic [1:0] val_ff;      // Written output levels
        logic [1:0] sync1_ff;    // First synchroniser stage
        logic [1:0] sync2_ff;    // Second stage, read value
    } pin_state_t;

    // Divider state
    typedef struct packed {
        logic [7:0] cnt_ff;      // Free running count
        logic       mod_tick_ff; // Quarter rate pulse
        logic       frm_tick_ff; // 1/256 rate pulse
    } div_state_t;

    // Field code to one-hot mode
    function automatic ck_mode_t sel_to_mode(input logic [1:0] sel);
        case (sel)
            `CKSEL_OFF:  sel_to_mode = CK_OFF;
            `CKSEL_FULL: sel_to_mode = CK_FULL;
            `CKSEL_HALF: sel_to_mode = CK_HALF;
            default:     sel_to_mode = CK_QUARTER;
        endcase
    endfunction

endpackage

// *** design/rate_divider.sv ***
/*
 * Free running divider on the master clock: half and quarter rate
 * levels, a phase end flag and one-cycle rate pulses.
 * Assumes ref_clk is the master clock and rstn the hard reset.
 */
`timescale 1ns/1ps
`include "adc_pin_consts.svh"
module rate_divider (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Divided outputs
    output logic      half_clk,
    output logic      quarter_clk,
    output logic      phase_end,
    output logic      mod_tick,
    output logic      frame_tick
);

    adc_pin_pkg::div_state_t st;   // Registered state
    adc_pin_pkg::div_state_t nxt;  // Next state

    // ****************************************************
    // Next state
    // ****************************************************
    // Counts every edge, never stopped by standby
    always_comb begin
        nxt = st;
        nxt.cnt_ff = st.cnt_ff + `DIV_CNT_STEP;
        nxt.mod_tick_ff = (st.cnt_ff[1:0] == `DIV_PHASE_END);
        nxt.frm_tick_ff = (st.cnt_ff == `DIV_FRAME_END);
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st.cnt_ff      <= `DIV_CNT_RST;
            st.mod_tick_ff <= 1'h0;
            st.frm_tick_ff <= 1'h0;
        end else begin
            st <= nxt;
        end
    end

    // Outputs straight from flops, phase_end decoded from the count
    assign half_clk    = st.cnt_ff[0];
    assign quarter_clk = st.cnt_ff[1];
    assign phase_end   = (st.cnt_ff[1:0] == `DIV_PHASE_END);
    assign mod_tick    = st.mod_tick_ff;
    assign frame_tick  = st.frm_tick_ff;

endmodule
